// >>> test/smc_mem_model.sv
// Three-wire serial memory model, 256 bytes, erased state all ones.
// Assumes chip select, serial clock and data from the controller.
`timescale 1ns/10ps
module smc_mem_model #(
  parameter int PROG_NS = 2000
) (
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic di_i,
  input  wire logic present_i,
  output logic      do_o,
  output logic      oe_o
);
  logic [7:0]  mem [256];
  logic [18:0] sr = 19'h0_0000;
  logic [7:0]  ra = 8'h00;
  int          cnt = 0;
  logic        ew_en = 1'b0;
  logic        rd_on = 1'b0;
  logic        pend = 1'b0;
  logic        prog = 1'b0;
  logic        rd_bit = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'ha5 + 8'(3 * i);
  // Ready shows only in the poll frame; read data also drives the line, elsewhere it floats
  assign oe_o = present_i && cs_i && (rd_on || pend);
  assign do_o = pend ? !prog : rd_bit;
  task automatic kick;
    pend = 1'b1;
    prog = 1'b1;
    prog <= #(PROG_NS) 1'b0;
  endtask
  always @(posedge sk_i) if (cs_i && present_i) begin
    if (cnt == 11 && sr[9:8] == 2'h2) begin
      rd_on = 1'b1;
      ra = sr[7:0];
    end
    if (rd_on && cnt < 19) rd_bit = mem[ra][18 - cnt];
    sr = {sr[17:0], di_i};
    cnt = cnt + 1;
  end
  always @(negedge cs_i) begin
    rd_on = 1'b0;
    if (cnt == 0) pend = 1'b0;
    if (cnt == 11 && sr[9:8] == 2'h0 && sr[7:6] == 2'h3) ew_en = 1'b1;
    if (cnt == 11 && sr[9:8] == 2'h0 && sr[7:6] == 2'h0) ew_en = 1'b0;
    if (ew_en && cnt == 11 && sr[9:8] == 2'h0 && sr[7:6] == 2'h2) begin
      mem = '{default: 8'hff};
      kick();
    end
    if (ew_en && cnt == 11 && sr[9:8] == 2'h3) begin
      mem[sr[7:0]] = 8'hff;
      kick();
    end
    if (ew_en && cnt == 19 && sr[17:16] == 2'h1) begin
      mem[sr[15:8]] = sr[7:0];
      kick();
    end
    if (ew_en && cnt == 19 && sr[17:16] == 2'h0) begin
      mem = '{default: sr[7:0]};
      kick();
    end
    cnt = 0;
  end
endmodule // smc_mem_model

// >>> test/smc_serial_memory_ctrl_checker.sv
// Port assertions for the serial memory command controller.
// Assumes a bind onto smc_serial_memory_ctrl; one clock, sync reset.
`timescale 1ns/10ps
module smc_serial_memory_ctrl_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 600000
) (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        mem_cs_o,
  input wire logic        mem_sk_o,
  input wire logic        serial_memory_data_pin_o,
  input wire logic        serial_memory_data_pin_oe_o,
  input wire logic        serial_memory_data_pin_i,
  input wire logic [2:0]  stn_sel_i,
  input wire logic [7:0]  stn_byte_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire logic rd_now = pready_o && !pwrite_i;
  wire logic dout   = serial_memory_data_pin_o;
  wire logic doe    = serial_memory_data_pin_oe_o;

  a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_map_err: assert property (pready_o |-> pslverr_o ==
    !(paddr_i == smc_pkg::ADDR_CMD || paddr_i == smc_pkg::ADDR_DATA))
    else $error("error flag wrong for address");
  a_idle_rdata: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access");
  a_data_rsvd: assert property (rd_now && paddr_i == smc_pkg::ADDR_DATA
    |-> prdata_o[31:8] == 24'h00_0000) else $error("data upper bits set");
  a_cmd_rsvd: assert property (rd_now && paddr_i == smc_pkg::ADDR_CMD
    |-> prdata_o[27:10] == 18'h0_0000) else $error("command reserved bits set");
  a_sk_framed: assert property (!mem_cs_o |-> !mem_sk_o)
    else $error("serial clock outside frame");
  a_oe_framed: assert property (doe |-> mem_cs_o)
    else $error("pin driven outside frame");
  a_start_bit: assert property ($rose(mem_cs_o) && doe |-> dout)
    else $error("frame lacks start bit");
  a_sk_high_len: assert property ($rose(mem_sk_o) |=> mem_sk_o [*8])
    else $error("serial clock high too short");
  a_dout_steady: assert property (mem_sk_o && $past(mem_sk_o) |-> $stable(dout))
    else $error("data moved while clock high");
  c_refused: cover property (pready_o && pslverr_o);
  c_poll: cover property ($rose(mem_cs_o) && !doe);
  c_read_in: cover property ($fell(doe) && mem_cs_o);
endmodule // smc_serial_memory_ctrl_checker

bind smc_serial_memory_ctrl smc_serial_memory_ctrl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_smc_serial_memory_ctrl_checker (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_cs_o, .mem_sk_o,
  .serial_memory_data_pin_o, .serial_memory_data_pin_oe_o, .serial_memory_data_pin_i,
  .stn_sel_i, .stn_byte_o);

// >>> test/smc_serial_memory_ctrl_tb_top.sv
// Testbench: controller on APB against the serial memory model.
// Assumes smc_pkg, design files and the checker are compiled first.
`timescale 1ns/10ps
module smc_serial_memory_ctrl_tb_top;
  localparam int unsigned TO_CYC = 2000;
  // Write frame of 19 serial periods plus the model's programming time
  localparam int unsigned WR_MIN = 19 * 20 + 40;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [2:0]  stn_sel_i = 3'h0;
  logic        present = 1'b1;
  logic        pull = 1'b1;
  logic [31:0] prdata_o, rdq;
  logic [7:0]  stn_byte_o;
  logic        pready_o, pslverr_o, mem_cs_o, mem_sk_o, rde, m_do, m_oe;
  logic        serial_memory_data_pin_o, serial_memory_data_pin_oe_o;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  // Unknown never reaches the pin: unowned line sits at the pull level
  wire logic serial_memory_data_pin_i = serial_memory_data_pin_oe_o ?
    serial_memory_data_pin_o : (m_oe ? m_do : pull);
  smc_serial_memory_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) u_smc_serial_memory_ctrl (.clk_sys_i,
    .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .mem_cs_o, .mem_sk_o, .serial_memory_data_pin_o, .serial_memory_data_pin_oe_o,
    .serial_memory_data_pin_i, .stn_sel_i, .stn_byte_o);
  smc_mem_model u_smc_mem_model (.cs_i(mem_cs_o), .sk_i(mem_sk_o),
    .di_i(serial_memory_data_pin_o), .present_i(present), .do_o(m_do), .oe_o(m_oe));
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rdq = prdata_o;
    rde = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic cmd(input smc_pkg::smc_op_t op, input logic [7:0] a);
    apb(1'b1, smc_pkg::ADDR_CMD, {1'b1, op, 20'h0_0000, a});
    do begin
      apb(1'b0, smc_pkg::ADDR_CMD, 32'h0000_0000);
    end while (rdq[31] !== 1'b0);
  endtask
  task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
    cmd(smc_pkg::OP_READ, a);
    apb(1'b0, smc_pkg::ADDR_DATA, 32'h0000_0000);
    check(rdq, {24'h00_0000, exp});
  endtask
  task automatic t_reset;
    apb(1'b0, smc_pkg::ADDR_CMD, 32'h0000_0000);
    check(32'(rdq[31]), 32'h0000_0001);
    cmd(smc_pkg::OP_READ, 8'h00);
    apb(1'b0, 8'hc0, 32'h0000_0000);
    check(32'(rde), 32'h0000_0001);
    apb(1'b1, smc_pkg::ADDR_CMD, 32'h0000_0007);
    apb(1'b0, smc_pkg::ADDR_CMD, 32'h0000_0000);
    check(rdq, 32'h0000_0107);
    for (int j = 0; j < 6; j++) begin
      stn_sel_i <= 3'(j);
      repeat (3) @(posedge clk_sys_i);
      check(32'(stn_byte_o), 32'(8'ha5 + 8'(3 * (j + 1))));
    end
    $display("t_reset done");
  endtask
  task automatic t_ops;
    int t0;
    apb(1'b1, smc_pkg::ADDR_DATA, 32'hffff_ff5a);
    apb(1'b0, smc_pkg::ADDR_DATA, 32'h0000_0000);
    check(rdq, 32'h0000_005a);
    cmd(smc_pkg::OP_WRITE, 8'h03);
    rd_at(8'h03, 8'hae);
    apb(1'b1, smc_pkg::ADDR_DATA, 32'h0000_005a);
    cmd(smc_pkg::OP_EW_ENABLE, 8'hc0);
    t0 = cyc;
    cmd(smc_pkg::OP_WRITE, 8'h03);
    check(32'(cyc - t0 >= WR_MIN), 32'h0000_0001);
    rd_at(8'h03, 8'h5a);
    cmd(smc_pkg::OP_ERASE, 8'h03);
    rd_at(8'h03, 8'hff);
    apb(1'b1, smc_pkg::ADDR_DATA, 32'h0000_003c);
    cmd(smc_pkg::OP_WRITE_ALL, 8'h40);
    check(rdq, 32'h4000_0140);
    rd_at(8'h80, 8'h3c);
    cmd(smc_pkg::OP_ERASE_ALL, 8'h80);
    rd_at(8'h80, 8'hff);
    cmd(smc_pkg::OP_EW_DISABLE, 8'h00);
    apb(1'b1, smc_pkg::ADDR_DATA, 32'h0000_003c);
    cmd(smc_pkg::OP_WRITE, 8'h03);
    rd_at(8'h03, 8'hff);
    cmd(smc_pkg::OP_RELOAD, 8'h00);
    check(rdq, 32'h7000_0000);
    $display("t_ops done");
  endtask
  task automatic t_tout;
    int t0;
    present <= 1'b0;
    pull <= 1'b0;
    t0 = cyc;
    cmd(smc_pkg::OP_WRITE, 8'h05);
    check(rdq, 32'h3000_0205);
    check(32'(cyc - t0 >= TO_CYC && cyc - t0 <= TO_CYC + 14), 32'h0000_0001);
    cmd(smc_pkg::OP_READ, 8'h05);
    check(rdq, 32'h0000_0005);
    pull <= 1'b1;
    cmd(smc_pkg::OP_ERASE_ALL, 8'h80);
    check(rdq, 32'h6000_0080);
    present <= 1'b1;
    $display("t_tout done");
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_ops();
    t_tout();
    final_report();
  end
endmodule // smc_serial_memory_ctrl_tb_top

// >>> verilog/smc_pkg.sv
// Constants, field layout and types for the serial memory command controller.
// Assumes a 20 MHz system clock and a three-wire serial memory, 8-bit organised.
package smc_pkg;
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TIMEOUT_MS  = 30;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;

  // Serial clock: one bit every SK_LAST+1 system cycles, high from SK_HALF on
  localparam logic [4:0] SK_HALF = 5'h0a;
  localparam logic [4:0] SK_LAST = 5'h13;

  localparam logic [7:0] ADDR_CMD  = 8'hb0;
  localparam logic [7:0] ADDR_DATA = 8'hb4;

  localparam int unsigned BUSY_BIT   = 31;
  localparam int unsigned CMD_HI     = 30;
  localparam int unsigned CMD_LO     = 28;
  localparam int unsigned TOUT_BIT   = 9;
  localparam int unsigned LOADED_BIT = 8;

  localparam logic [7:0]  SIG_VALID = 8'ha5;
  localparam logic [2:0]  STN_FIRST = 3'h0;
  localparam logic [2:0]  STN_LAST  = 3'h6;
  localparam logic [2:0]  STN_STEP  = 3'h1;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [17:0] RSVD_CMD  = 18'h0_0000;
  localparam logic [23:0] RSVD_DATA = 24'h00_0000;

  // Serial frame: start bit, two opcode bits, eight address bits, eight data bits
  localparam logic [4:0] FRAME_HDR  = 5'h0b;
  localparam logic [4:0] FRAME_DATA = 5'h13;
  localparam logic [4:0] RX_BYTE    = 5'h08;
  localparam logic [4:0] RX_NONE    = 5'h00;
  localparam logic       START_BIT  = 1'b1;

  localparam logic [1:0] SER_EXT   = 2'h0;
  localparam logic [1:0] SER_WRITE = 2'h1;
  localparam logic [1:0] SER_READ  = 2'h2;
  localparam logic [1:0] SER_ERASE = 2'h3;
  localparam logic [1:0] EXT_DISABLE   = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE    = 2'h3;

  typedef enum logic [2:0] {
    OP_READ, OP_EW_DISABLE, OP_EW_ENABLE, OP_WRITE,
    OP_WRITE_ALL, OP_ERASE, OP_ERASE_ALL, OP_RELOAD
  } smc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_SHIFT, ST_GAP, ST_POLL, ST_STEP
  } smc_state_t;
endpackage

// >>> verilog/smc_serial_memory_ctrl.sv
// Serial memory command controller: APB register pair, serial frame engine,
// ready polling with timeout, and station address reload from the memory.
// Assumes an APB master on clk_sys_i and a three-wire serial memory on pins.
//
// Function
// R1 - Writing busy bit 31 starts the command; busy stays set until it finishes.
// R2 - Software leaves command and data registers alone while busy.
// R3 - Command field bits 30-28 selects one of eight operations.
// R4 - After reset busy is set until the station address reload ends.
// R5 - After disable, enable must be sent before erase or write works.
// R6 - Memory accepts erase and write after enable until disable or power loss.
// R7 - Memory powers up with erase and write disabled.
// R8 - Write sends the data byte to the addressed location.
// R9 - Write-all stores the data byte in every location.
// R10 - Erase clears only the addressed location.
// R11 - Erase-all starts a bulk erase of the whole memory.
// R12 - Reload rereads station address; first byte not 0xA5 means failure.
// R13 - No memory answer within 30 ms ends the operation and sets timeout bit 9.
// R14 - Data pin pulled high without memory: command ends after its frame.
// R15 - Only erase and write commands can time out with the pin pulled low.
// R16 - Address loaded bit 8 is set after a successful station address load.
// R17 - Address field bits 7-0 addresses the memory and resets to zero.
// R18 - Data bits 7-0 hold the read or write byte; upper bits read zero.
// R19 - Commands are framed serially with a generated serial clock.
// R20 - Starting a command clears the timeout bit.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module smc_serial_memory_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = smc_pkg::TIMEOUT_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             mem_cs_o,
  output logic             mem_sk_o,
  output logic             serial_memory_data_pin_o,
  output logic             serial_memory_data_pin_oe_o,
  input  wire logic        serial_memory_data_pin_i,
  input  wire logic [2:0]  stn_sel_i,
  output logic      [7:0]  stn_byte_o
);
  localparam logic [19:0] TMO_LAST = 20'(TIMEOUT_CYCLES - 1);

  smc_pkg::smc_state_t st;
  smc_pkg::smc_state_t next_st;
  smc_pkg::smc_op_t    cmd_op;

  logic [7:0]  cmd_addr;
  logic [7:0]  data_byte;
  logic        busy;
  logic        tout;
  logic        loaded;
  logic        din_meta;
  logic        din_sync;
  logic [4:0]  ph;
  logic [4:0]  bit_cnt;
  logic [18:0] tx;
  logic [7:0]  rx;
  logic [2:0]  idx;
  logic [19:0] tmr;

  // Bus decode
  wire acc       = psel_i & penable_i;
  wire sel_cmd   = (paddr_i == smc_pkg::ADDR_CMD);
  wire sel_data  = (paddr_i == smc_pkg::ADDR_DATA);
  wire mapped    = sel_cmd | sel_data;
  wire commit    = acc & pready_o;
  wire wr_cmd    = commit & pwrite_i & sel_cmd;
  wire wr_data   = commit & pwrite_i & sel_data;
  // Writes while busy are dropped so a running frame never sees its operands move
  wire wr_ok     = ~busy;                                               // [R2]
  wire start     = wr_cmd & wr_ok & pwdata_i[smc_pkg::BUSY_BIT];        // [R1]
  wire [31:0] rd_cmd  = {busy, cmd_op, smc_pkg::RSVD_CMD, tout, loaded, cmd_addr};
  wire [31:0] rd_dat  = {smc_pkg::RSVD_DATA, data_byte};                // [R18]
  wire [31:0] rd_mux  = sel_cmd ? rd_cmd : (sel_data ? rd_dat : 32'h0000_0000);

  // Operation decode
  wire op_reload = (cmd_op == smc_pkg::OP_RELOAD);
  wire op_read   = (cmd_op == smc_pkg::OP_READ);
  wire op_wr     = (cmd_op == smc_pkg::OP_WRITE);
  wire op_write_all_locations_cmd   = (cmd_op == smc_pkg::OP_WRITE_ALL);
  wire op_er     = (cmd_op == smc_pkg::OP_ERASE);
  wire op_erase_all_locations_cmd   = (cmd_op == smc_pkg::OP_ERASE_ALL);
  wire op_erase_write_enable_cmd   = (cmd_op == smc_pkg::OP_EW_ENABLE);
  wire op_erase_write_disable_cmd   = (cmd_op == smc_pkg::OP_EW_DISABLE);
  wire is_ext    = op_erase_write_enable_cmd | op_erase_write_disable_cmd | op_write_all_locations_cmd | op_erase_all_locations_cmd;
  // Only erase and write forms wait for the memory's ready answer
  wire polls     = op_wr | op_write_all_locations_cmd | op_er | op_erase_all_locations_cmd;                   // [R15]
  wire has_data  = op_wr | op_write_all_locations_cmd;
  wire has_rx    = op_read | op_reload;

  wire [1:0] ext_code = op_erase_write_enable_cmd ? smc_pkg::EXT_ENABLE :                 // [R5]
                        op_write_all_locations_cmd ? smc_pkg::EXT_WRITE_ALL :              // [R9]
                        op_erase_all_locations_cmd ? smc_pkg::EXT_ERASE_ALL :              // [R11]
                                  smc_pkg::EXT_DISABLE;
  wire [1:0] ser_op   = is_ext ? smc_pkg::SER_EXT :
                        op_wr  ? smc_pkg::SER_WRITE :                   // [R8]
                        op_er  ? smc_pkg::SER_ERASE :                   // [R10]
                                 smc_pkg::SER_READ;
  wire [7:0] ser_addr = is_ext    ? {ext_code, 6'h00} :
                        op_reload ? {5'h00, idx} :                      // [R12]
                                    cmd_addr;                           // [R17]
  wire [18:0] frame   = {smc_pkg::START_BIT, ser_op, ser_addr, data_byte}; // [R19]
  wire [4:0] frame_len = has_data ? smc_pkg::FRAME_DATA : smc_pkg::FRAME_HDR;
  wire [4:0] rx_len    = has_rx ? smc_pkg::RX_BYTE : smc_pkg::RX_NONE;
  wire [4:0] total_len = frame_len + rx_len;
  wire       tx_phase  = (bit_cnt < frame_len);
  wire [7:0] rx_shift  = {rx[6:0], din_sync};

  // Sequencing events
  wire in_shift  = (st == smc_pkg::ST_SHIFT);
  wire bit_end   = in_shift & (ph == smc_pkg::SK_LAST);
  wire frame_end = bit_end & (bit_cnt == total_len - 5'h01);
  wire in_gap    = (st == smc_pkg::ST_GAP);
  wire in_rest   = (st == smc_pkg::ST_IDLE) | (st == smc_pkg::ST_LOAD);
  wire gap_end   = in_gap & (ph == smc_pkg::SK_LAST);
  wire in_poll   = (st == smc_pkg::ST_POLL);
  wire ph_run    = in_shift | in_gap | in_poll;
  // Chip select and the pin synchroniser lag the state, so the ready answer
  // is only trusted at the end of each serial period
  wire poll_tick = in_poll & (ph == smc_pkg::SK_LAST);
  wire poll_ok   = poll_tick & din_sync;                                // [R14]
  wire tmo_hit   = in_poll & ~din_sync & (tmr >= TMO_LAST);             // [R13]
  wire in_step   = (st == smc_pkg::ST_STEP);
  wire sig_bad   = in_step & (idx == smc_pkg::STN_FIRST) & (rx != smc_pkg::SIG_VALID); // [R12]
  wire stn_done  = in_step & ~sig_bad & (idx == smc_pkg::STN_LAST);     // [R16]
  wire stn_wr    = in_step & ~sig_bad & (idx != smc_pkg::STN_FIRST);
  wire [2:0] stn_waddr = idx - smc_pkg::STN_STEP;
  // Frames without polling or reload steps end busy on their own last serial clock
  wire plain_end = frame_end & ~polls & ~op_reload;                     // [R14]
  wire finish    = plain_end | poll_ok | tmo_hit | sig_bad | stn_done;  // [R1]
  wire read_end  = frame_end & op_read;
  wire cs_next   = in_shift | in_poll;
  wire sk_next   = in_shift & (ph >= smc_pkg::SK_HALF);
  wire oe_next   = in_shift & tx_phase;

  always_comb begin
    next_st = st;
    unique case (st)
      smc_pkg::ST_IDLE:  if (start) next_st = smc_pkg::ST_LOAD;
      smc_pkg::ST_LOAD:  next_st = smc_pkg::ST_SHIFT;
      smc_pkg::ST_SHIFT: begin
        if (frame_end) begin
          next_st = polls     ? smc_pkg::ST_GAP :
                    op_reload ? smc_pkg::ST_STEP : smc_pkg::ST_IDLE;
        end
      end
      // Chip select stays low for one serial period between frames
      smc_pkg::ST_GAP: begin
        if (gap_end) begin
          next_st = polls ? smc_pkg::ST_POLL : smc_pkg::ST_LOAD;
        end
      end
      smc_pkg::ST_POLL:  if (poll_ok | tmo_hit) next_st = smc_pkg::ST_IDLE;
      smc_pkg::ST_STEP:  next_st = (sig_bad | stn_done) ? smc_pkg::ST_IDLE : smc_pkg::ST_GAP;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= serial_memory_data_pin_i;
      din_sync <= din_meta;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      prdata_o  <= (acc & ~pready_o & ~pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // Reset starts a station address reload at once
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st       <= smc_pkg::ST_LOAD;                                     // [R4]
      cmd_op   <= smc_pkg::OP_RELOAD;
      cmd_addr <= smc_pkg::BYTE_ZERO;                                   // [R17]
    end else begin
      st <= next_st;
      if (wr_cmd & wr_ok) begin
        cmd_op   <= smc_pkg::smc_op_t'(pwdata_i[smc_pkg::CMD_HI:smc_pkg::CMD_LO]); // [R3]
        cmd_addr <= pwdata_i[7:0];                                      // [R17]
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy   <= 1'b1;                                                   // [R4]
      tout   <= 1'b0;
      loaded <= 1'b0;
    end else begin
      if (start) begin
        busy <= 1'b1;                                                   // [R1]
      end else if (finish) begin
        busy <= 1'b0;                                                   // [R4]
      end
      if (tmo_hit) begin
        tout <= 1'b1;                                                   // [R13]
      end else if (start) begin
        tout <= 1'b0;                                                   // [R20]
      end
      if (stn_done) begin
        loaded <= 1'b1;                                                 // [R16]
      end else if (sig_bad) begin
        loaded <= 1'b0;                                                 // [R12]
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      data_byte <= smc_pkg::BYTE_ZERO;                                  // [R18]
    end else if (read_end) begin
      data_byte <= rx_shift;                                            // [R18]
    end else if (wr_data & wr_ok) begin
      data_byte <= pwdata_i[7:0];                                       // [R18]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i | in_rest) begin
      ph <= 5'h00;
    end else if (ph_run & (ph != smc_pkg::SK_LAST)) begin
      ph <= ph + 5'h01;
    end else begin
      ph <= 5'h00;
    end
  end

  // Bit engine: output changes while the serial clock is low, input sampled late high
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bit_cnt <= 5'h00;
      tx      <= 19'h0_0000;
      rx      <= smc_pkg::BYTE_ZERO;
    end else if (st == smc_pkg::ST_LOAD) begin
      bit_cnt <= 5'h00;
      tx      <= frame;                                                 // [R19]
      rx      <= smc_pkg::BYTE_ZERO;
    end else if (bit_end) begin
      bit_cnt <= bit_cnt + 5'h01;
      tx      <= {tx[17:0], 1'b0};                                      // [R19]
      if (~tx_phase) begin
        rx <= rx_shift;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i | start) begin
      idx <= smc_pkg::STN_FIRST;
      tmr <= 20'h0_0000;
    end else begin
      if (in_step & ~finish) begin
        idx <= idx + smc_pkg::STN_STEP;                                 // [R12]
      end
      if ((st != smc_pkg::ST_IDLE) & (tmr != TMO_LAST)) begin
        tmr <= tmr + 20'h0_0001;                                        // [R13]
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mem_cs_o                    <= 1'b0;
      mem_sk_o                    <= 1'b0;
      serial_memory_data_pin_o    <= 1'b0;
      serial_memory_data_pin_oe_o <= 1'b0;
    end else begin
      mem_cs_o                    <= cs_next;                           // [R19]
      mem_sk_o                    <= sk_next;                           // [R19]
      serial_memory_data_pin_o    <= tx[18];
      serial_memory_data_pin_oe_o <= oe_next;
    end
  end

  smc_stn_mem u_stn_mem (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (stn_wr),
    .wr_addr_i (stn_waddr),
    .wr_data_i (rx),
    .rd_addr_i (stn_sel_i),
    .rd_data_o (stn_byte_o)
  );
endmodule // smc_serial_memory_ctrl

// >>> verilog/smc_stn_mem.sv
// Station address store: eight bytes, one write port, registered read port.
// Assumes writer and reader share clk_sys_i.
`timescale 1ns/10ps
module smc_stn_mem (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_en_i,
  input  wire logic [2:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [2:0] rd_addr_i,
  output logic      [7:0] rd_data_o
);
  logic [7:0] mem [8];

  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Unwritten entries may read unknown; a reload fills entries 0-5 only, never 6 and 7
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_data_o <= smc_pkg::BYTE_ZERO;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // smc_stn_mem
